// ==== afsr_defines.svh ====
`ifndef AFSR_DEFINES_SVH
`define AFSR_DEFINES_SVH

// ****************************************
// register offsets and resets
// ****************************************
`define AFSR_OFS_THRESH      8'h09
`define AFSR_OFS_STATUS      8'h0a
`define AFSR_OFS_FAULT       8'h0b
`define AFSR_RST_THRESH      8'h22
`define AFSR_RST_STATUS      8'h00
`define AFSR_RST_FAULT       8'h18

// ****************************************
// field positions
// ****************************************
`define AFSR_ST_UV           6
`define AFSR_ST_GAIN         5
`define AFSR_ST_CLIP         4
`define AFSR_ST_OC           3
`define AFSR_ST_OTF          2
`define AFSR_ST_OTW          1
`define AFSR_ST_BAT          0
`define AFSR_FC_GAIN_HI      7
`define AFSR_FC_GAIN_LO      6
`define AFSR_FC_MANUAL_RECOVERY_TRIGGER         5
`define AFSR_FC_MAX_HI       4
`define AFSR_FC_MAX_LO       3
`define AFSR_FC_UV           2
`define AFSR_FC_OT           1
`define AFSR_FC_OC           0

// ****************************************
// limiter modes, cut codes and retry hold
// ****************************************
`define AFSR_LIM_MUTE        2'h2
`define AFSR_LIM_LOW_ONLY    2'h3
`define AFSR_CUT_NONE        3'h0
`define AFSR_CUT_1P5         3'h1
`define AFSR_CUT_3           3'h2
`define AFSR_CUT_5           3'h3
`define AFSR_RETRY_HOLD      8'h3f

`endif

// ==== afsr_pkg.sv ====
package afsr_pkg;
  typedef enum logic [1:0] {
    AFSR_RUN,
    AFSR_SHUT,
    AFSR_RETRY,
    AFSR_LOCK
  } afsr_state_t;
endpackage

// ==== afsr_regs.sv ====
`timescale 1ns/1ps
`include "afsr_defines.svh"

module afsr_regs
  import afsr_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic      [7:0] reg_rdata,
  input  wire logic [7:0] battery_sense,
  input  wire logic [1:0] limiter_mode_select,
  input  wire logic       regulator_undervoltage_flag,
  input  wire logic       gain_reduction_engaged_flag,
  input  wire logic       clip_detect,
  input  wire logic       overcurrent_fault_flag,
  input  wire logic       overtemperature_fault_flag,
  input  wire logic       thermal_warning_flag,
  output logic      [7:0] battery_knee_threshold,
  output logic      [2:0] thermal_warning_gain_cut,
  output logic            output_mute,
  output logic            limiter_allow,
  output logic            amp_shutdown,
  output logic            recovery_pulse
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [14:0] sync1_ff;
  logic [14:0] sync2_ff;
  logic [14:0] nxt_sync1;
  logic [14:0] nxt_sync2;

  always_comb begin
    nxt_sync1 = {battery_sense, limiter_mode_select,
                 regulator_undervoltage_flag, gain_reduction_engaged_flag,
                 clip_detect, overcurrent_fault_flag,
                 overtemperature_fault_flag};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      sync1_ff <= 15'h0000;
      sync2_ff <= 15'h0000;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  logic [1:0] warn_sync_ff;
  logic [1:0] nxt_warn_sync;
  always_comb begin
    nxt_warn_sync = {warn_sync_ff[0], thermal_warning_flag};
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      warn_sync_ff <= 2'h0;
    end else begin
      warn_sync_ff <= nxt_warn_sync;
    end
  end

  logic [7:0] bat_s;
  logic [1:0] mode_s;
  logic       uv_s;
  logic       gain_s;
  logic       clip_s;
  logic       oc_s;
  logic       otf_s;
  logic       otw_s;
  always_comb begin
    bat_s  = sync2_ff[14:7];
    mode_s = sync2_ff[6:5];
    uv_s   = sync2_ff[4];
    gain_s = sync2_ff[3];
    clip_s = sync2_ff[2];
    oc_s   = sync2_ff[1];
    otf_s  = sync2_ff[0];
    otw_s  = warn_sync_ff[1];
  end

  // ****************************************
  // registers
  // ****************************************
  // threshold code is the raw sense code; volts are 3.8+12.4*code/255
  logic [7:0] thresh_ff;
  logic [7:0] nxt_thresh;
  logic [7:0] fault_ff;
  logic [7:0] nxt_fault;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic       manual_recovery_trigger_req;
  logic       bat_low;

  always_comb begin
    nxt_thresh = thresh_ff;
    nxt_fault  = fault_ff;
    manual_recovery_trigger_req   = 1'b0;
    if (reg_wr && reg_addr == `AFSR_OFS_THRESH) begin
      nxt_thresh = reg_wdata;
    end
    if (reg_wr && reg_addr == `AFSR_OFS_FAULT) begin
      // trigger bit is write-only, never stored
      nxt_fault  = reg_wdata & ~(8'h01 << `AFSR_FC_MANUAL_RECOVERY_TRIGGER);
      manual_recovery_trigger_req   = reg_wdata[`AFSR_FC_MANUAL_RECOVERY_TRIGGER];
    end
    // same code scale as the battery readout
    bat_low = (bat_s <= thresh_ff);
    // status is live; bus writes never reach it
    nxt_status = 8'h00;
    nxt_status[`AFSR_ST_UV]   = uv_s;
    nxt_status[`AFSR_ST_GAIN] = gain_s;
    nxt_status[`AFSR_ST_CLIP] = clip_s;
    nxt_status[`AFSR_ST_OC]   = oc_s;
    nxt_status[`AFSR_ST_OTF]  = otf_s;
    nxt_status[`AFSR_ST_OTW]  = otw_s;
    nxt_status[`AFSR_ST_BAT]  = bat_low;
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        `AFSR_OFS_THRESH: nxt_rdata = thresh_ff;
        `AFSR_OFS_STATUS: nxt_rdata = status_ff;
        `AFSR_OFS_FAULT:  nxt_rdata = fault_ff;
        default:          nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      thresh_ff <= `AFSR_RST_THRESH;
      fault_ff  <= `AFSR_RST_FAULT;
      status_ff <= `AFSR_RST_STATUS;
      rdata_ff  <= 8'h00;
    end else begin
      thresh_ff <= nxt_thresh;
      fault_ff  <= nxt_fault;
      status_ff <= nxt_status;
      rdata_ff  <= nxt_rdata;
    end
  end

  // ****************************************
  // limiter and gain outputs
  // ****************************************
  logic [2:0] cut_ff;
  logic [2:0] nxt_cut;
  logic       mute_ff;
  logic       nxt_mute;
  logic       allow_ff;
  logic       nxt_allow;

  always_comb begin
    nxt_cut = `AFSR_CUT_NONE;
    if (otw_s) begin
      unique case (fault_ff[`AFSR_FC_GAIN_HI:`AFSR_FC_GAIN_LO])
        2'h0: nxt_cut = `AFSR_CUT_NONE;
        2'h1: nxt_cut = `AFSR_CUT_1P5;
        2'h2: nxt_cut = `AFSR_CUT_3;
        2'h3: nxt_cut = `AFSR_CUT_5;
      endcase
    end
    // mute holds only while strictly below the knee
    nxt_mute  = (mode_s == `AFSR_LIM_MUTE) && (bat_s < thresh_ff);
    nxt_allow = (mode_s == `AFSR_LIM_LOW_ONLY) ? (bat_s < thresh_ff)
              : mode_s[0];
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cut_ff   <= `AFSR_CUT_NONE;
      mute_ff  <= 1'b0;
      allow_ff <= 1'b0;
    end else begin
      cut_ff   <= nxt_cut;
      mute_ff  <= nxt_mute;
      allow_ff <= nxt_allow;
    end
  end

  // ****************************************
  // fault recovery
  // ****************************************
  afsr_state_t state_ff;
  afsr_state_t nxt_state;
  logic [7:0]  wait_ff;
  logic [7:0]  nxt_wait;
  logic [2:0]  tries_ff;
  logic [2:0]  nxt_tries;
  logic [2:0]  cause_ff;
  logic [2:0]  nxt_cause;
  logic [2:0]  seen;
  logic        pulse_ff;
  logic        nxt_pulse;
  logic        fault_any;
  logic        manual_needed;
  logic [2:0]  limit;
  logic        unlimited;

  always_comb begin
    fault_any = uv_s | otf_s | oc_s;
    // faults stay latched so a manual select outlives the pin
    seen = cause_ff | {uv_s, otf_s, oc_s};
    manual_needed = (seen[2] & fault_ff[`AFSR_FC_UV])
                  | (seen[1] & fault_ff[`AFSR_FC_OT])
                  | (seen[0] & fault_ff[`AFSR_FC_OC]);
    unlimited = (fault_ff[`AFSR_FC_MAX_HI:`AFSR_FC_MAX_LO] == 2'h3);
    unique case (fault_ff[`AFSR_FC_MAX_HI:`AFSR_FC_MAX_LO])
      2'h0:    limit = 3'd1;
      2'h1:    limit = 3'd3;
      default: limit = 3'd7;
    endcase
    nxt_state = state_ff;
    nxt_wait  = wait_ff;
    nxt_tries = tries_ff;
    nxt_pulse = 1'b0;
    nxt_cause = seen;
    unique case (state_ff)
      AFSR_RUN: begin
        if (fault_any) begin
          nxt_state = AFSR_SHUT;
        end else begin
          nxt_tries = 3'd0;
        end
      end
      AFSR_SHUT: begin
        if (manual_recovery_trigger_req) begin
          nxt_state = AFSR_RETRY;
          nxt_pulse = 1'b1;
          nxt_wait  = `AFSR_RETRY_HOLD;
          nxt_cause = 3'h0;
        end else if (!manual_needed && !fault_any) begin
          if (unlimited || tries_ff < limit) begin
            nxt_state = AFSR_RETRY;
            nxt_pulse = 1'b1;
            nxt_wait  = `AFSR_RETRY_HOLD;
            nxt_tries = unlimited ? tries_ff : tries_ff + 3'd1;
            nxt_cause = 3'h0;
          end else begin
            nxt_state = AFSR_LOCK;
          end
        end
      end
      AFSR_RETRY: begin
        // hold off so a fault that returns at once counts as a new try
        if (fault_any) begin
          nxt_state = AFSR_SHUT;
        end else if (wait_ff == 8'h00) begin
          nxt_state = AFSR_RUN;
        end else begin
          nxt_wait = wait_ff - 8'h01;
        end
      end
      AFSR_LOCK: begin
        if (manual_recovery_trigger_req) begin
          nxt_state = AFSR_RETRY;
          nxt_pulse = 1'b1;
          nxt_wait  = `AFSR_RETRY_HOLD;
          nxt_tries = 3'd0;
          nxt_cause = 3'h0;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= AFSR_RUN;
      wait_ff  <= 8'h00;
      tries_ff <= 3'd0;
      cause_ff <= 3'h0;
      pulse_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      wait_ff  <= nxt_wait;
      tries_ff <= nxt_tries;
      cause_ff <= nxt_cause;
      pulse_ff <= nxt_pulse;
    end
  end

  logic shut_ff;
  logic nxt_shut;
  always_comb begin
    nxt_shut = (nxt_state == AFSR_SHUT) || (nxt_state == AFSR_LOCK);
  end
  always_ff @(posedge mclk) begin
    if (rst) begin
      shut_ff <= 1'b0;
    end else begin
      shut_ff <= nxt_shut;
    end
  end

  always_comb begin
    reg_rdata                = rdata_ff;
    battery_knee_threshold   = thresh_ff;
    thermal_warning_gain_cut = cut_ff;
    output_mute              = mute_ff;
    limiter_allow            = allow_ff;
    amp_shutdown             = shut_ff;
    recovery_pulse           = pulse_ff;
  end

endmodule // afsr_regs

// ==== afsr_regs_assertions.sv ====
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module afsr_regs_assertions (
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [1:0] limiter_mode_select,
  input wire logic       regulator_undervoltage_flag,
  input wire logic       overcurrent_fault_flag,
  input wire logic       overtemperature_fault_flag,
  input wire logic       thermal_warning_flag,
  input wire logic [7:0] battery_knee_threshold,
  input wire logic [2:0] thermal_warning_gain_cut,
  input wire logic       output_mute,
  input wire logic       limiter_allow,
  input wire logic       amp_shutdown,
  input wire logic       recovery_pulse
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_knee_wr;
    reg_wr && reg_addr == 8'h09 |=> battery_knee_threshold == $past(reg_wdata);
  endproperty
  a_knee_wr: assert property (p_knee_wr) else $error("knee lost");
  property p_st_top;
    reg_rd && reg_addr == 8'h0a |=> reg_rdata[7] == 1'b0;
  endproperty
  a_st_top: assert property (p_st_top) else $error("status b7");
  property p_manual_recovery_trigger_rd;
    reg_rd && reg_addr == 8'h0b |=> reg_rdata[5] == 1'b0;
  endproperty
  a_manual_recovery_trigger_rd: assert property (p_manual_recovery_trigger_rd) else $error("trigger read");
  property p_unmapped;
    reg_rd && reg_addr > 8'h0b |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped");
  property p_no_mute;
    (limiter_mode_select != 2'h2) [*4] |-> output_mute == 1'b0;
  endproperty
  a_no_mute: assert property (p_no_mute) else $error("mute");
  property p_allow;
    (limiter_mode_select == 2'h1) [*4] |-> limiter_allow == 1'b1;
  endproperty
  a_allow: assert property (p_allow) else $error("allow");
  property p_cut_idle;
    (!thermal_warning_flag) [*4] |-> thermal_warning_gain_cut == 3'h0;
  endproperty
  a_cut_idle: assert property (p_cut_idle) else $error("cut");
  property p_shut_cause;
    $rose(amp_shutdown) |-> $past(overcurrent_fault_flag, 3) ||
      $past(overtemperature_fault_flag, 3) ||
      $past(regulator_undervoltage_flag, 3);
  endproperty
  a_shut_cause: assert property (p_shut_cause) else $error("shut");
  property p_pulse_gap;
    recovery_pulse |-> ##1 (!recovery_pulse) [*8];
  endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("pulse");
  property p_pulse_src;
    recovery_pulse |-> $past(amp_shutdown);
  endproperty
  a_pulse_src: assert property (p_pulse_src) else $error("src");
endmodule // afsr_regs_assertions

bind afsr_regs afsr_regs_assertions chk_u (.mclk, .rst, .reg_wr, .reg_rd,
  .reg_addr, .reg_wdata, .reg_rdata, .limiter_mode_select,
  .regulator_undervoltage_flag, .overcurrent_fault_flag,
  .overtemperature_fault_flag, .thermal_warning_flag,
  .battery_knee_threshold, .thermal_warning_gain_cut, .output_mute,
  .limiter_allow, .amp_shutdown, .recovery_pulse);

// ==== afsr_host.sv ====
`timescale 1ns/1ps
// ****************************************
// control host model
// ****************************************
module afsr_host (
  input  wire logic       mclk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'hff;
    reg_wdata = 8'h00;
  end
  // volts to code; mv must be at least 3800
  function automatic logic [7:0] code_of_mv(input int mv);
    return 8'((mv - 3800) * 255 / 12400);
  endfunction
  // idle lines inverted so a stale address never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, d,
                      output logic [7:0] q);
    @(posedge mclk);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask
endmodule // afsr_host

// ==== amp_fault_status_recovery_regs_test.sv ====
`timescale 1ns/1ps
// ****************************************
// self-checking bench
// ****************************************
module amp_fault_status_recovery_regs_test;
  logic       mclk, rst, reg_wr, reg_rd, output_mute, limiter_allow;
  logic       amp_shutdown, recovery_pulse;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, battery_sense, knee;
  logic [6:1] flg;
  logic [1:0] mode;
  logic [2:0] cut;
  int         err_count, n_checks, m_thr, m_ctl, pulses, p0;
  afsr_host host_u (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata);
  afsr_regs dut_u (.mclk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .reg_rdata, .battery_sense, .limiter_mode_select(mode),
    .regulator_undervoltage_flag(flg[6]), .gain_reduction_engaged_flag(flg[5]),
    .clip_detect(flg[4]), .overcurrent_fault_flag(flg[3]),
    .overtemperature_fault_flag(flg[2]), .thermal_warning_flag(flg[1]),
    .battery_knee_threshold(knee), .thermal_warning_gain_cut(cut),
    .output_mute, .limiter_allow, .amp_shutdown, .recovery_pulse);
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  always @(negedge mclk) if (recovery_pulse === 1'b1) pulses++;
  task automatic chk(input logic [7:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    logic [7:0] q;
    host_u.xfer(1'b1, a, d, q);
    if (a == 8'h09) m_thr = d;
    if (a == 8'h0b) m_ctl = d & 8'hdf;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    logic [7:0] q;
    host_u.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  function automatic logic [7:0] exp_st();
    return {1'b0, flg, battery_sense <= m_thr[7:0]};
  endfunction
  task automatic wrap_up();
    if (err_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #40000;
    err_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'h95056a55));
    rst = 1'b1;
    battery_sense = 8'h80;
    mode = 2'h0;
    flg = 6'h00;
    m_thr = 8'h22;
    m_ctl = 8'h18;
    cyc(4);
    rst = 1'b0;
    rdc(8'h09, 8'h22);
    rdc(8'h0a, 8'h00);
    rdc(8'h0b, 8'h18);
    for (int i = 0; i < 4; i++) begin
      wr(8'h09, 8'($urandom));
      rdc(8'h09, m_thr);
      chk(knee, m_thr);
      wr(8'h0b, 8'($urandom));
      rdc(8'h0b, m_ctl);
    end
    wr(8'h0b, 8'h18);
    wr(8'h0a, 8'hff);
    rdc(8'h0a, exp_st());
    rdc(8'h0c + 8'($urandom_range(243)), 8'h00);
    for (int b = 1; b <= 6; b++) begin
      flg = 6'(1 << (b - 1));
      cyc(4);
      rdc(8'h0a, exp_st());
    end
    flg = 6'h00;
    cyc(80);
    wr(8'h09, host_u.code_of_mv(8000));
    battery_sense = m_thr;
    mode = 2'h2;
    cyc(4);
    rdc(8'h0a, exp_st());
    chk(output_mute, 1'b0);
    battery_sense = m_thr - 1;
    cyc(4);
    rdc(8'h0a, exp_st());
    chk(output_mute, 1'b1);
    mode = 2'h3;
    cyc(4);
    chk(limiter_allow, 1'b1);
    battery_sense = m_thr;
    cyc(4);
    chk(limiter_allow, 1'b0);
    mode = 2'h1;
    cyc(4);
    chk(limiter_allow, 1'b1);
    flg[1] = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(8'h0b, 8'((c << 6) | 8'h18));
      cyc(4);
      chk(cut, 3'(c));
    end
    flg = 6'h00;
    wr(8'h0b, 8'h18);
    p0 = pulses;
    flg[3] = 1'b1;
    cyc(6);
    chk(amp_shutdown, 1'b1);
    flg = 6'h00;
    cyc(8);
    chk(8'(pulses - p0), 8'h01);
    cyc(70);
    chk(amp_shutdown, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wr(8'h0b, 8'(8'h18 | (1 << k)));
      p0 = pulses;
      flg[k == 0 ? 3 : k == 1 ? 2 : 6] = 1'b1;
      cyc(6);
      flg = 6'h00;
      cyc(20);
      chk(amp_shutdown, 1'b1);
      chk(8'(pulses - p0), 8'h00);
      wr(8'h0b, 8'(8'h38 | (1 << k)));
      cyc(3);
      chk(8'(pulses - p0), 8'h01);
      cyc(70);
      chk(amp_shutdown, 1'b0);
    end
    wr(8'h0b, 8'h00);
    p0 = pulses;
    flg[3] = 1'b1;
    cyc(6);
    flg = 6'h00;
    cyc(8);
    flg[3] = 1'b1;
    cyc(6);
    flg = 6'h00;
    cyc(20);
    chk(8'(pulses - p0), 8'h01);
    chk(amp_shutdown, 1'b1);
    wr(8'h0b, 8'h20);
    cyc(70);
    chk(8'(pulses - p0), 8'h02);
    chk(amp_shutdown, 1'b0);
    wrap_up();
  end
endmodule // amp_fault_status_recovery_regs_test
